// ===== hdl/lcdh_core.v
// Behaviour
// - Glyph RAM holds sixteen 5x8 characters
// - Icons take 8, 4 or 0 glyphs
// - Blinking icons double glyph usage
// - Upper nibble zero selects glyph RAM
// - Cursor underline/blink at address counter
// - Two 8-bit host latches: command, data
// - Control bit7 continuation, bits5..0 zero
// - Select 0 command, 1 data
// - Serial direction comes with slave address
// - Direction 0 write, 1 read
// - Busy flag high while executing
// - Busy holds back all but status read
// - Command read returns busy and counter
// - Data latch readable and writable
// - Data write steps address by one
// - Display shift accompanies data write
// - Commands sorted into three classes
// - Data latch loaded after host read
// - Function bit selects extended set
`timescale 1ns/1ps
`default_nettype none
`include "lcdh_regs.vh"
module lcdh_core (
  input wire mclk,
  input wire resetn,
  input wire serial_mode,
  input wire bus_select,
  input wire bus_dir,
  input wire bus_strobe,
  input wire [7:0] bus_wdata,
  input wire ser_start,
  input wire ser_stop,
  input wire ser_dir,
  input wire ser_byte_valid,
  input wire [7:0] ser_byte,
  input wire ext_osc_sel,
  input wire ext_osc,
  input wire [7:0] glyph_code,
  output reg [7:0] bus_rdata,
  output reg rdata_valid,
  output reg busy_flag,
  output reg [6:0] address_counter,
  output reg extended_set,
  output reg cursor_underline,
  output reg cursor_blink,
  output reg display_shift_pulse,
  output reg [4:0] icon_glyph_count,
  output reg glyph_from_ram,
  output reg ram_write,
  output reg glyph_target,
  output reg [6:0] ram_addr,
  output reg [7:0] ram_wdata,
  output reg byte_error,
  output reg fifo_ready
);
  // Class codes of commands
  localparam CL_CONFIG = 2'd0;
  localparam CL_ADDR = 2'd1;
  localparam CL_XFER = 2'd2;
  localparam CL_OTHER = 2'd3;
  // Serial parser states
  localparam SP_IDLE = 2'd0;
  localparam SP_CTRL = 2'd1;
  localparam SP_BYTE = 2'd2;
  localparam SP_STREAM = 2'd3;

  reg [1:0] sp_state;
  reg sp_sel;
  reg sp_dir;
  reg [2:0] sync_strobe;
  reg [2:0] sync_start;
  reg [2:0] sync_stop;
  reg [2:0] sync_bval;
  reg [2:0] sync_osc;
  reg [18:0] pin_m;
  reg [18:0] pin_q;
  reg [7:0] command_latch;
  reg [7:0] ram_transfer_latch;
  reg step_inc;
  reg shift_on_write;
  reg icon_on;
  reg icon_blink;
  reg [7:0] busy_ticks;
  reg [7:0] osc_div;
  reg osc_tick;
  reg [7:0] glyph_mem [0:`LCDH_GLYPH_CHARS*8-1];
  reg [7:0] text_mem [0:(1 << `LCDH_TEXT_ADDR_W) - 1];
  wire strobe_rise;
  wire start_rise;
  wire stop_rise;
  wire bval_rise;
  wire osc_rise;
  wire [9:0] fifo_out;
  wire fifo_out_valid;
  wire fifo_in_ready;
  wire fifo_pop;
  wire pend_sel;
  wire pend_dir;
  wire [7:0] pend_data;
  reg push_valid;
  reg [9:0] push_data;

  // Command class decode, used in one place
  function [1:0] cmd_class;
    input [7:0] c;
    begin
      if ((c & `LCDH_MASK_TEXT) == `LCDH_OP_TEXT ||
          (c & `LCDH_MASK_GLYPH) == `LCDH_OP_GLYPH)
        cmd_class = CL_ADDR;
      else if ((c & `LCDH_MASK_FUNC) == `LCDH_OP_FUNC)
        cmd_class = CL_CONFIG;
      else
        cmd_class = CL_OTHER;
    end
  endfunction

  // Next address, one step either way
  function [6:0] step_addr;
    input [6:0] a;
    input inc;
    begin
      step_addr = inc ? a + 7'h01 : a - 7'h01;
    end
  endfunction

  // Two-stage synchronisers; third stage for edge detect
  always @(posedge mclk) begin
    pin_m <= {ser_dir, bus_select, bus_dir, bus_wdata, ser_byte}; // Held fields, two stages
    pin_q <= pin_m;
    if (!resetn) begin
      sync_strobe <= 3'h0;
      sync_start <= 3'h0;
      sync_stop <= 3'h0;
      sync_bval <= 3'h0;
      sync_osc <= 3'h0;
    end else begin
      sync_strobe <= {sync_strobe[1:0], bus_strobe};
      sync_start <= {sync_start[1:0], ser_start};
      sync_stop <= {sync_stop[1:0], ser_stop};
      sync_bval <= {sync_bval[1:0], ser_byte_valid};
      sync_osc <= {sync_osc[1:0], ext_osc};
    end
  end
  assign strobe_rise = sync_strobe[1] & ~sync_strobe[2];
  assign start_rise = sync_start[1] & ~sync_start[2];
  assign stop_rise = sync_stop[1] & ~sync_stop[2];
  assign bval_rise = sync_bval[1] & ~sync_bval[2];
  assign osc_rise = sync_osc[1] & ~sync_osc[2];

  // Internal or external oscillator tick
  always @(posedge mclk) begin
    if (!resetn) begin
      osc_div <= 8'h00;
      osc_tick <= 1'b0;
    end else if (ext_osc_sel) begin
      osc_div <= 8'h00;
      osc_tick <= osc_rise;
    end else begin
      osc_tick <= (osc_div == `LCDH_OSC_DIV);
      osc_div <= (osc_div == `LCDH_OSC_DIV) ? 8'h00 : osc_div + 8'h01;
    end
  end

  // Serial parser: control byte then payload
  always @(posedge mclk) begin
    if (!resetn) begin
      sp_state <= SP_IDLE;
      sp_sel <= `LCDH_SEL_CMD;
      sp_dir <= `LCDH_DIR_WRITE;
      push_valid <= 1'b0;
      push_data <= 10'h000;
      byte_error <= 1'b0;
    end else begin
      push_valid <= 1'b0;
      byte_error <= 1'b0;
      if (!serial_mode) begin
        sp_state <= SP_IDLE;
        if (strobe_rise) begin
          push_valid <= 1'b1;
          push_data <= pin_q[17:8];
        end
      end else if (stop_rise) begin
        sp_state <= SP_IDLE;
      end else if (start_rise) begin
        sp_state <= SP_CTRL;
        sp_dir <= pin_q[18];
      end else if (bval_rise) begin
        case (sp_state)
          SP_CTRL: begin
            sp_sel <= pin_q[`LCDH_CB_SEL];
            byte_error <= |(pin_q[7:0] & `LCDH_CB_ZERO_MASK);
            sp_state <= pin_q[`LCDH_CB_CONT] ? SP_BYTE : SP_STREAM;
          end
          SP_BYTE: begin
            push_valid <= 1'b1;
            push_data <= {sp_sel, sp_dir, pin_q[7:0]};
            sp_state <= SP_CTRL;
          end
          SP_STREAM: begin
            push_valid <= 1'b1;
            push_data <= {sp_sel, sp_dir, pin_q[7:0]};
          end
          default: begin
            sp_state <= SP_IDLE;
          end
        endcase
      end
    end
  end

  // Request buffer between host side and executor
  lcdh_fifo #(
    .WIDTH(10),
    .DEPTH(`LCDH_FIFO_DEPTH),
    .AW(4)
  ) u_fifo (
    .mclk(mclk),
    .resetn(resetn),
    .in_data(push_data),
    .in_valid(push_valid),
    .in_ready(fifo_in_ready),
    .out_data(fifo_out),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop)
  );
  assign pend_sel = fifo_out[9];
  assign pend_dir = fifo_out[8];
  assign pend_data = fifo_out[7:0];
  // Status reads pass while busy; all else waits for busy_flag to clear
  assign fifo_pop = fifo_out_valid &&
    ((pend_sel == `LCDH_SEL_CMD && pend_dir == `LCDH_DIR_READ) || !busy_flag);

  // Executor: latches, busy timing, address stepping
  always @(posedge mclk) begin
    if (!resetn) begin
      command_latch <= `LCDH_RST_CMD;
      ram_transfer_latch <= `LCDH_RST_DATA;
      address_counter <= `LCDH_RST_ADDR;
      glyph_target <= 1'b0;
      busy_flag <= 1'b0;
      busy_ticks <= 8'h00;
      extended_set <= 1'b0;
      step_inc <= 1'b1;
      shift_on_write <= 1'b0;
      cursor_underline <= 1'b0;
      cursor_blink <= 1'b0;
      icon_on <= 1'b0;
      icon_blink <= 1'b0;
      display_shift_pulse <= 1'b0;
      bus_rdata <= 8'h00;
      rdata_valid <= 1'b0;
      ram_write <= 1'b0;
      ram_addr <= `LCDH_RST_ADDR;
      ram_wdata <= 8'h00;
      fifo_ready <= 1'b0;
    end else begin
      display_shift_pulse <= 1'b0;
      rdata_valid <= 1'b0;
      ram_write <= 1'b0;
      fifo_ready <= fifo_in_ready;
      // Busy countdown on oscillator ticks
      if (busy_flag && osc_tick) begin
        busy_ticks <= busy_ticks - 8'h01;
        if (busy_ticks == 8'h01) begin
          busy_flag <= 1'b0;
        end
      end
      if (fifo_pop) begin
        if (pend_sel == `LCDH_SEL_CMD && pend_dir == `LCDH_DIR_READ) begin
          bus_rdata <= {busy_flag, address_counter};
          rdata_valid <= 1'b1;
        end else if (pend_sel == `LCDH_SEL_CMD) begin
          command_latch <= pend_data;
          busy_flag <= 1'b1;
          busy_ticks <= `LCDH_TICKS_SHORT;
          case (cmd_class(pend_data))
            CL_CONFIG: begin
              extended_set <= pend_data[`LCDH_BIT_EXT];
            end
            CL_ADDR: begin
              glyph_target <= !pend_data[7];
              address_counter <= pend_data[7] ? pend_data[6:0] : {1'b0, pend_data[5:0]};
            end
            default: begin
              if (!extended_set && pend_data == `LCDH_OP_CLEAR) begin
                address_counter <= `LCDH_RST_ADDR;
                glyph_target <= 1'b0;
                busy_ticks <= `LCDH_TICKS_CLEAR;
              end else if (!extended_set && pend_data == `LCDH_OP_HOME) begin
                address_counter <= `LCDH_RST_ADDR;
              end else if (!extended_set &&
                  (pend_data & `LCDH_MASK_ENTRY) == `LCDH_OP_ENTRY) begin
                step_inc <= pend_data[`LCDH_BIT_INC];
                shift_on_write <= pend_data[`LCDH_BIT_SHIFT];
              end else if (!extended_set &&
                  (pend_data & `LCDH_MASK_DISP) == `LCDH_OP_DISP) begin
                cursor_underline <= pend_data[`LCDH_BIT_CURS_UL];
                cursor_blink <= pend_data[`LCDH_BIT_CURS_BL];
              end else if (extended_set &&
                  (pend_data & `LCDH_MASK_ICON) == `LCDH_OP_ICON) begin
                icon_on <= pend_data[`LCDH_BIT_ICON_ON];
                icon_blink <= pend_data[`LCDH_BIT_ICON_BLINK];
              end
            end
          endcase
        end else if (pend_dir == `LCDH_DIR_WRITE) begin
          ram_transfer_latch <= pend_data;
          ram_write <= 1'b1;
          ram_addr <= address_counter;
          ram_wdata <= pend_data;
          address_counter <= step_addr(address_counter, step_inc);
          display_shift_pulse <= shift_on_write;
          busy_flag <= 1'b1;
          busy_ticks <= `LCDH_TICKS_SHORT;
        end else begin
          bus_rdata <= ram_transfer_latch;
          rdata_valid <= 1'b1;
          ram_transfer_latch <= glyph_target ?
            glyph_mem[address_counter] : text_mem[address_counter];
          address_counter <= step_addr(address_counter, step_inc);
          busy_flag <= 1'b1;
          busy_ticks <= `LCDH_TICKS_SHORT;
        end
      end
    end
  end

  // Glyph and text storage
  always @(posedge mclk) begin
    if (ram_write && glyph_target) begin
      glyph_mem[ram_addr] <= ram_wdata;
    end
    if (ram_write && !glyph_target) begin
      text_mem[ram_addr] <= ram_wdata;
    end
  end

  // Icon share of glyph RAM and code space split
  always @(posedge mclk) begin
    if (!resetn) begin
      icon_glyph_count <= `LCDH_ICON_NONE;
      glyph_from_ram <= 1'b0;
    end else begin
      icon_glyph_count <= !icon_on ? `LCDH_ICON_NONE :
        (icon_blink ? `LCDH_ICON_BLINK_CHARS : `LCDH_ICON_STEADY_CHARS);
      glyph_from_ram <= (glyph_code[7:4] == `LCDH_USER_NIBBLE);
    end
  end
endmodule // lcdh_core
`default_nettype wire

// ===== hdl/lcdh_regs.vh
`ifndef LCDH_REGS_VH
`define LCDH_REGS_VH
// Register select and direction encodings
`define LCDH_SEL_CMD 1'b0
`define LCDH_SEL_DATA 1'b1
`define LCDH_DIR_WRITE 1'b0
`define LCDH_DIR_READ 1'b1
// Control byte fields
`define LCDH_CB_CONT 7
`define LCDH_CB_SEL 6
`define LCDH_CB_ZERO_MASK 8'h3f
// Command codes and masks
`define LCDH_OP_CLEAR 8'h01
`define LCDH_OP_HOME 8'h02
`define LCDH_MASK_FUNC 8'he0
`define LCDH_OP_FUNC 8'h20
`define LCDH_MASK_ENTRY 8'hfc
`define LCDH_OP_ENTRY 8'h04
`define LCDH_MASK_DISP 8'hf8
`define LCDH_OP_DISP 8'h08
`define LCDH_MASK_SHIFT 8'hf0
`define LCDH_OP_SHIFT 8'h10
`define LCDH_MASK_ICON 8'hf8
`define LCDH_OP_ICON 8'h08
`define LCDH_MASK_GLYPH 8'hc0
`define LCDH_OP_GLYPH 8'h40
`define LCDH_MASK_TEXT 8'h80
`define LCDH_OP_TEXT 8'h80
// Command field positions
`define LCDH_BIT_EXT 0
`define LCDH_BIT_INC 1
`define LCDH_BIT_SHIFT 0
`define LCDH_BIT_CURS_UL 1
`define LCDH_BIT_CURS_BL 0
`define LCDH_BIT_ICON_ON 2
`define LCDH_BIT_ICON_BLINK 1
// Execution times in oscillator ticks
`define LCDH_TICKS_SHORT 8'd3
`define LCDH_TICKS_CLEAR 8'd165
`define LCDH_OSC_DIV 8'd63
// Glyph space
`define LCDH_GLYPH_CHARS 16
`define LCDH_GLYPH_ADDR_W 7
`define LCDH_TEXT_ADDR_W 7
`define LCDH_ICON_BLINK_CHARS 5'd8
`define LCDH_ICON_STEADY_CHARS 5'd4
`define LCDH_ICON_NONE 5'd0
`define LCDH_USER_NIBBLE 4'h0
// Reset values
`define LCDH_RST_CMD 8'h00
`define LCDH_RST_DATA 8'h00
`define LCDH_RST_ADDR 7'h00
`define LCDH_FIFO_DEPTH 16
`endif

// ===== hdl/lcdh_fifo.v
`timescale 1ns/1ps
`default_nettype none
module lcdh_fifo #(
  parameter WIDTH = 10,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire mclk,
  input wire resetn,
  input wire [WIDTH-1:0] in_data,
  input wire in_valid,
  output wire in_ready,
  output reg [WIDTH-1:0] out_data,
  output reg out_valid,
  input wire out_ready
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0] count;
  wire push;
  wire pop;
  wire [AW:0] depth_n;
  wire [31:0] depth_w;
  assign depth_w = DEPTH;
  assign depth_n = depth_w[AW:0];
  // Honest full and registered read side
  assign in_ready = (count != depth_n);
  assign pop = (count != {(AW+1){1'b0}}) && (!out_valid || out_ready);
  assign push = in_valid && in_ready;
  always @(posedge mclk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end
  // Pointers, count and output register
  always @(posedge mclk) begin
    if (!resetn) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
      out_valid <= 1'b0;
      out_data <= {WIDTH{1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + {{(AW-1){1'b0}}, 1'b1};
      end
      if (pop) begin
        rd_ptr <= rd_ptr + {{(AW-1){1'b0}}, 1'b1};
        out_data <= mem[rd_ptr];
        out_valid <= 1'b1;
      end else if (out_ready) begin
        out_valid <= 1'b0;
      end
      count <= count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule // lcdh_fifo
`default_nettype wire

// ===== verification/lcdh_props.sv
`timescale 1ns/1ps
`default_nettype none
// Port-level checks of the host front end
module lcdh_props (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [7:0] glyph_code,
  input wire logic glyph_from_ram,
  input wire logic [4:0] icon_glyph_count,
  input wire logic rdata_valid,
  input wire logic busy_flag,
  input wire logic [6:0] address_counter,
  input wire logic ram_write,
  input wire logic [6:0] ram_addr,
  input wire logic byte_error,
  input wire logic serial_mode
);
  logic [13:0] blen;
  // Length of the current busy spell
  always_ff @(posedge mclk) begin
    if (!resetn) blen <= 14'h0000;
    else blen <= busy_flag ? blen + 14'h0001 : 14'h0000;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  a_glyph_ram_sel: assert property ($past(resetn) |->
    glyph_from_ram == ($past(glyph_code[7:4]) == 4'h0)) else $error("glyph source wrong");
  a_icon_count_set: assert property (
    icon_glyph_count inside {5'h00, 5'h04, 5'h08}) else $error("icon glyph count illegal");
  a_rdata_one_cycle: assert property (rdata_valid |=> !rdata_valid)
    else $error("read answer too long");
  // Clear spell plus 144 cycles of slack
  a_busy_max_len: assert property (blen <= 14'h29d0)
    else $error("busy spell too long");
  a_busy_min_len: assert property ($fell(busy_flag) |-> blen >= 14'h003c)
    else $error("busy spell too short");
  a_addr_step_one: assert property (ram_write |-> ##[0:4]
    (address_counter == ram_addr + 7'h01 || address_counter == ram_addr - 7'h01))
    else $error("address did not step");
  a_error_serial_pulse: assert property (byte_error |-> serial_mode ##1 !byte_error)
    else $error("control byte flag wrong");
  a_reset_idle_out: assert property (@(posedge mclk) disable iff (1'b0)
    !resetn |=> !busy_flag && !rdata_valid && address_counter == 7'h00)
    else $error("outputs not idle in reset");
  c_busy: cover property ($rose(busy_flag));
  c_read: cover property (rdata_valid);
  c_write: cover property (ram_write);
  c_error: cover property (byte_error);
endmodule // lcdh_props
bind lcdh_core lcdh_props lcdh_props_i (.mclk(mclk), .resetn(resetn),
  .glyph_code(glyph_code), .glyph_from_ram(glyph_from_ram),
  .icon_glyph_count(icon_glyph_count), .rdata_valid(rdata_valid), .busy_flag(busy_flag),
  .address_counter(address_counter), .ram_write(ram_write), .ram_addr(ram_addr),
  .byte_error(byte_error), .serial_mode(serial_mode));
`default_nettype wire

// ===== verification/lcdh_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// Host side: parallel strobes and serial byte stream
module lcdh_host_model (
  input wire logic mclk,
  output logic serial_mode,
  output logic bus_select,
  output logic bus_dir,
  output logic bus_strobe,
  output logic [7:0] bus_wdata,
  output logic ser_start,
  output logic ser_stop,
  output logic ser_dir,
  output logic ser_byte_valid,
  output logic [7:0] ser_byte
);
  // Idle levels at time zero
  initial begin
    {serial_mode, bus_select, bus_dir, bus_strobe, bus_wdata} = 12'h000;
    {ser_start, ser_stop, ser_dir, ser_byte_valid, ser_byte} = 12'h000;
  end
  // Parallel access, fields held around the strobe
  task automatic par(input logic sel, input logic dir, input logic [7:0] d);
    @(negedge mclk);
    bus_select = sel;
    bus_dir = dir;
    bus_wdata = d;
    bus_strobe = 1'b1;
    repeat (4) @(negedge mclk);
    bus_strobe = 1'b0;
    repeat (2) @(negedge mclk);
    bus_wdata = ~d;
  endtask
  // Start or stop condition, direction set with the address
  task automatic ser_cond(input logic stop, input logic dir);
    @(negedge mclk);
    ser_dir = dir;
    if (stop) ser_stop = 1'b1;
    else ser_start = 1'b1;
    repeat (4) @(negedge mclk);
    {ser_start, ser_stop} = 2'b00;
    repeat (4) @(negedge mclk);
  endtask
  // One byte, released line shows the inverse
  task automatic ser_tx(input logic [7:0] b);
    @(negedge mclk);
    ser_byte = b;
    repeat (2) @(negedge mclk);
    ser_byte_valid = 1'b1;
    repeat (4) @(negedge mclk);
    ser_byte_valid = 1'b0;
    repeat (2) @(negedge mclk);
    ser_byte = ~b;
  endtask
  // Control byte: continuation, select, six zero bits
  task automatic ser_ctrl(input logic cont, input logic sel);
    ser_tx({cont, sel, 6'h00});
  endtask
endmodule // lcdh_host_model
`default_nettype wire

// ===== verification/lcd_host_register_access_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "lcdh_regs.vh"
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin mismatches++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
module lcd_host_register_access_tb;
  logic mclk, resetn, ext_osc_sel, ext_osc, serial_mode, bus_select, bus_dir, bus_strobe;
  logic ser_start, ser_stop, ser_dir, ser_byte_valid, rdata_valid, busy_flag, extended_set;
  logic cursor_underline, cursor_blink, display_shift_pulse, glyph_from_ram, ram_write;
  logic glyph_target, byte_error, fifo_ready, wr_tgt;
  logic [7:0] glyph_code, bus_rdata, bus_wdata, ser_byte, ram_wdata, rd_val, wr_data, v;
  logic [6:0] address_counter, ram_addr, wr_addr;
  logic [4:0] icon_glyph_count;
  int mismatches = 0, checked = 0, rd_n = 0, wr_n = 0, sh_n = 0, er_n = 0, fl_n = 0, n, n0, k;
  lcdh_core lcdh_core_i (.mclk(mclk), .resetn(resetn), .serial_mode(serial_mode),
    .bus_select(bus_select), .bus_dir(bus_dir), .bus_strobe(bus_strobe),
    .bus_wdata(bus_wdata), .ser_start(ser_start), .ser_stop(ser_stop), .ser_dir(ser_dir),
    .ser_byte_valid(ser_byte_valid), .ser_byte(ser_byte), .ext_osc_sel(ext_osc_sel),
    .ext_osc(ext_osc), .glyph_code(glyph_code), .bus_rdata(bus_rdata),
    .rdata_valid(rdata_valid), .busy_flag(busy_flag), .address_counter(address_counter),
    .extended_set(extended_set), .cursor_underline(cursor_underline),
    .cursor_blink(cursor_blink), .display_shift_pulse(display_shift_pulse),
    .icon_glyph_count(icon_glyph_count), .glyph_from_ram(glyph_from_ram),
    .ram_write(ram_write), .glyph_target(glyph_target), .ram_addr(ram_addr),
    .ram_wdata(ram_wdata), .byte_error(byte_error), .fifo_ready(fifo_ready));
  lcdh_host_model lcdh_host_model_i (.mclk(mclk), .serial_mode(serial_mode),
    .bus_select(bus_select), .bus_dir(bus_dir), .bus_strobe(bus_strobe),
    .bus_wdata(bus_wdata), .ser_start(ser_start), .ser_stop(ser_stop), .ser_dir(ser_dir),
    .ser_byte_valid(ser_byte_valid), .ser_byte(ser_byte));
  // Core clock and free-running oscillator of unrelated phase
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  initial begin
    ext_osc = 1'b0;
    #13;
    forever #80 ext_osc = ~ext_osc;
  end
  // Record answers, RAM writes, shifts and flagged bytes
  always @(posedge mclk) begin
    if (rdata_valid) rd_n++;
    if (rdata_valid) rd_val = bus_rdata;
    if (ram_write) {wr_tgt, wr_addr, wr_data} = {glyph_target, ram_addr, ram_wdata};
    if (ram_write) wr_n++;
    if (display_shift_pulse) sh_n++;
    if (byte_error) er_n++;
    if (fifo_ready === 1'b0) fl_n++;
  end
  task automatic rd(input logic sel, output logic [7:0] r);
    int c;
    int j;
    c = rd_n;
    lcdh_host_model_i.par(sel, `LCDH_DIR_READ, 8'h00);
    for (j = 0; j < 40 && rd_n == c; j++) @(negedge mclk);
    `CHK(rd_n != c, 1'b1)
    r = rd_val;
  endtask
  task automatic status(output logic [7:0] r);
    rd(`LCDH_SEL_CMD, r);
  endtask
  // Poll the busy flag before the next instruction
  task automatic wait_idle;
    logic [7:0] r;
    int j;
    for (j = 0; j < 1500; j++) begin
      status(r);
      if (r[7] === 1'b0) break;
    end
    `CHK(r[7], 1'b0)
  endtask
  task automatic wr(input logic sel, input logic [7:0] d);
    lcdh_host_model_i.par(sel, `LCDH_DIR_WRITE, d);
    wait_idle;
  endtask
  task automatic spell(output int len);
    int j;
    len = 0;
    for (j = 0; j < 40 && busy_flag !== 1'b1; j++) @(negedge mclk);
    while (busy_flag === 1'b1 && len < 12000) begin
      @(negedge mclk);
      len++;
    end
  endtask
  task automatic t_reset;
    `CHK({busy_flag, extended_set, icon_glyph_count}, 7'h00)
    status(v);
    `CHK(v, 8'h00)
  endtask
  task automatic t_text;
    wr(`LCDH_SEL_CMD, `LCDH_OP_TEXT | 8'h05);
    wr(`LCDH_SEL_CMD, 8'h06);
    wr(`LCDH_SEL_DATA, 8'h41);
    `CHK({wr_tgt, wr_addr, wr_data}, {1'b0, 7'h05, 8'h41})
    status(v);
    `CHK(v, 8'h06)
    wr(`LCDH_SEL_CMD, 8'h05);
    n0 = sh_n;
    wr(`LCDH_SEL_DATA, 8'h42);
    status(v);
    `CHK(v, 8'h05)
    `CHK(sh_n - n0, 1)
  endtask
  task automatic t_glyph;
    for (k = 0; k < 16; k++) begin
      glyph_code = {k[3:0], 4'h5};
      repeat (2) @(negedge mclk);
      `CHK(glyph_from_ram, k == 0)
    end
    wr(`LCDH_SEL_CMD, `LCDH_OP_GLYPH | 8'h03);
    wr(`LCDH_SEL_DATA, 8'h1f);
    `CHK({wr_tgt, wr_addr, wr_data}, {1'b1, 7'h03, 8'h1f})
    // Read back: latch first, then the byte at the address
    wr(`LCDH_SEL_DATA, 8'h0a);
    wr(`LCDH_SEL_CMD, `LCDH_OP_GLYPH | 8'h03);
    rd(`LCDH_SEL_DATA, v);
    `CHK(v, 8'h0a)
    wait_idle;
    rd(`LCDH_SEL_DATA, v);
    `CHK(v, 8'h1f)
    wait_idle;
  endtask
  task automatic t_busy;
    lcdh_host_model_i.par(`LCDH_SEL_CMD, `LCDH_DIR_WRITE, `LCDH_OP_CLEAR);
    status(v);
    `CHK(v[7], 1'b1)
    spell(n);
    `CHK(n > 10400 && n <= 10624, 1'b1)
    lcdh_host_model_i.par(`LCDH_SEL_CMD, `LCDH_DIR_WRITE, 8'h00);
    spell(n);
    `CHK(n >= 128 && n <= 192, 1'b1)
    ext_osc_sel = 1'b1;
    lcdh_host_model_i.par(`LCDH_SEL_CMD, `LCDH_DIR_WRITE, 8'h00);
    spell(n);
    `CHK(n >= 80 && n <= 130, 1'b1)
    ext_osc_sel = 1'b0;
  endtask
  task automatic t_modes;
    wr(`LCDH_SEL_CMD, `LCDH_OP_FUNC | 8'h01);
    `CHK(extended_set, 1'b1)
    wr(`LCDH_SEL_CMD, 8'h0c);
    `CHK(icon_glyph_count, `LCDH_ICON_STEADY_CHARS)
    wr(`LCDH_SEL_CMD, 8'h0e);
    `CHK(icon_glyph_count, `LCDH_ICON_BLINK_CHARS)
    wr(`LCDH_SEL_CMD, 8'h08);
    `CHK(icon_glyph_count, `LCDH_ICON_NONE)
    wr(`LCDH_SEL_CMD, `LCDH_OP_FUNC);
    `CHK(extended_set, 1'b0)
    wr(`LCDH_SEL_CMD, 8'h0e);
    `CHK({cursor_underline, cursor_blink}, 2'b10)
    wr(`LCDH_SEL_CMD, 8'h0d);
    `CHK({cursor_underline, cursor_blink}, 2'b01)
  endtask
  task automatic t_serial;
    lcdh_host_model_i.serial_mode = 1'b1;
    n0 = wr_n;
    lcdh_host_model_i.ser_cond(1'b0, `LCDH_DIR_WRITE);
    lcdh_host_model_i.ser_ctrl(1'b1, `LCDH_SEL_CMD);
    lcdh_host_model_i.ser_tx(8'h06);
    lcdh_host_model_i.ser_ctrl(1'b1, `LCDH_SEL_CMD);
    lcdh_host_model_i.ser_tx(`LCDH_OP_TEXT | 8'h20);
    lcdh_host_model_i.ser_ctrl(1'b0, `LCDH_SEL_DATA);
    lcdh_host_model_i.ser_tx(8'h55);
    lcdh_host_model_i.ser_tx(8'h56);
    for (k = 0; k < 2000 && wr_n < n0 + 2; k++) @(negedge mclk);
    `CHK({wr_addr, wr_data}, {7'h21, 8'h56})
    lcdh_host_model_i.ser_cond(1'b1, `LCDH_DIR_WRITE);
    n0 = er_n;
    n = wr_n;
    lcdh_host_model_i.ser_cond(1'b0, `LCDH_DIR_WRITE);
    lcdh_host_model_i.ser_tx(8'h41);
    lcdh_host_model_i.ser_tx(8'h57);
    for (k = 0; k < 1000 && wr_n == n; k++) @(negedge mclk);
    `CHK({er_n - n0, wr_data}, {32'd1, 8'h57})
    lcdh_host_model_i.ser_cond(1'b1, `LCDH_DIR_WRITE);
    lcdh_host_model_i.serial_mode = 1'b0;
  endtask
  task automatic t_fifo;
    fl_n = 0;
    for (k = 0; k < 24; k++) lcdh_host_model_i.par(`LCDH_SEL_CMD, `LCDH_DIR_WRITE, 8'h00);
    `CHK(fl_n > 0, 1'b1)
    // Drain the queue: busy must stay low for ten cycles
    n = 0;
    for (k = 0; k < 6000 && n < 10; k++) begin
      @(negedge mclk);
      n = (busy_flag === 1'b0) ? n + 1 : 0;
    end
    wait_idle;
    `CHK(fifo_ready, 1'b1)
  endtask
  task automatic report_and_stop;
    if (mismatches == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    {resetn, ext_osc_sel, glyph_code} = 10'h000;
    repeat (2) @(negedge mclk);
    resetn = 1'b1;
    repeat (3) @(negedge mclk);
    t_reset;
    t_text;
    t_glyph;
    t_busy;
    t_modes;
    t_serial;
    t_fifo;
    report_and_stop;
  end
  // Hang guard well beyond the expected run
  initial begin
    #380000;
    mismatches++;
    report_and_stop;
  end
endmodule // lcd_host_register_access_tb
`default_nettype wire
